// ---- core/ir_relay_pkg.sv ----
// types shared by the thermometer sequencer
`default_nettype none
package ir_relay_pkg;

  typedef enum logic [2:0] {
    SEQ_LOAD  = 3'b000,
    SEQ_START = 3'b001,
    SEQ_WAIT  = 3'b011,
    SEQ_PROC  = 3'b010,
    SEQ_CALC  = 3'b110,
    SEQ_PULSE = 3'b111
  } seq_state_e;

  typedef enum logic [2:0] {
    STEP_AMB_OFS = 3'h0,
    STEP_AMB_DIE = 3'h1,
    STEP_IR_OFS  = 3'h2,
    STEP_IR_GAIN = 3'h3,
    STEP_ZONE1   = 3'h4,
    STEP_ZONE2   = 3'h5
  } step_e;

endpackage
`default_nettype wire

// ---- core/ir_relay_regs.svh ----
// nonvolatile word map, ram word map, field positions and timing counts
`ifndef IR_RELAY_REGS_SVH
`define IR_RELAY_REGS_SVH

`define NVM_PULSE_CFG 6'h02
`define NVM_HYST 6'h20
`define NVM_THR 6'h21
`define NVM_RESCALE_MIN 6'h22
`define NVM_FILTER_CFG 6'h25
`define NVM_WORDS 3'h5

`define PCFG_EN_BIT 1
`define PCFG_DRIVE_BIT 2
`define PCFG_RELAY_BIT 3
`define FCFG_FIR_LSB 0
`define FCFG_IIR_LSB 4
`define FCFG_DUAL_BIT 8
`define FCFG_SENSOR_BIT 9
`define FCFG_SHIFT_LSB 12

`define RAM_ZONE1_FILTERED_IR 4'h4
`define RAM_ZONE2_FILTERED_IR 4'h5
`define RAM_TA 4'h6
`define RAM_ZONE1_OBJECT_TEMP 4'h7
`define RAM_ZONE2_OBJECT_TEMP 4'h8
`define RAM_TOS 4'h9
`define RAM_TD 4'ha
`define RAM_IR_OFFSET_RESULT 4'hb
`define RAM_IRG 4'hc
`define RAM_KG 4'hd

`define TA_LOW 16'h2de4
`define TA_HIGH 16'h4dc4
`define KG_BASE 16'h8000
`define KG_FRAC 14
`define FIXED_FIR_LOG2 3'h3
`define FIXED_IIR_SHIFT 3'h2
`define PULSE_MAX 10'h3ff

`define CLK_MHZ 100
`define REQ_TIME_US 1000
`define REQ_CYCLES (`REQ_TIME_US * `CLK_MHZ)

`endif

// ---- core/ir_thermometer_relay_output.sv ----
// measurement sequencer, result words, pulse reload and shared pin control
`include "ir_relay_regs.svh"
`default_nettype none
//
// Function
// - pulse output disabled in config: shared pin is serial data right after reset
// - ambient result in word 006h, 0.02 K per lsb, clamped 2de4h..4dc4h
// - object results stored as absolute temperature, 0.02 K per lsb
// - load calibration after reset, then loop measurement continuously
// - ambient: fixed offset filters, die FIR, compensation, IIR, ambient calc
// - common IR stage: offset, gain with compensation, then gain factor
// - per zone FIR, offset and gain compensation, IIR, object temp; zone 2 optional
// - one shared FIR length and one shared IIR length setting
// - each pass ends by rescaling temperatures to 10 bits and loading the pulser
// - relay compares zone 1 object temperature, drives a logic level
// - relay mode needs relay-select bit in word 002h and pulse enable
// - pin driver push-pull or open-drain by drive-type bit
// - threshold from word 021h, hysteresis from word 020h
// - pin high at or above threshold+hyst, low at or below threshold-hyst
// - relay mode keeps measuring; same request switches it to serial
// - relay resumes after leaving it only through a reset or a sleep exit
module ir_thermometer_relay_output
  import ir_relay_pkg::*;
#(
  parameter int REQ_CYCLES = `REQ_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  output logic o_nvm_rd,
  output logic [5:0] o_nvm_addr,
  input wire logic i_nvm_ack,
  input wire logic [15:0] i_nvm_rdata,
  output logic o_adc_start,
  output logic [2:0] o_adc_chan,
  input wire logic i_adc_done,
  input wire logic [15:0] i_adc_data,
  input wire logic [3:0] i_ram_rd_addr,
  output logic [15:0] o_ram_rd_data,
  output logic o_pulse_load,
  output logic [9:0] o_pulse_word1,
  output logic [9:0] o_pulse_word2,
  input wire logic i_pulse_level,
  input wire logic i_scl_pin,
  input wire logic i_sda_pin,
  output logic o_sda_sync,
  input wire logic i_serial_drive_low,
  input wire logic i_sleep_exit,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_serial_mode,
  output logic o_relay_mode,
  output logic o_dual_zone,
  output logic o_die_sensor_sel
);
  logic [15:0] ram_q [16];
  seq_state_e state_q;
  step_e step_q;
  logic [2:0] load_idx_q;
  logic nvm_busy_q;
  logic [15:0] pcfg_q, hyst_q, thr_q, rmin_q, fcfg_q;
  logic [7:0] cnt_q;
  logic [22:0] acc_q;
  logic fixed_len, last_sample, calc_en, wr_en;
  logic [2:0] fir_log2, iir_shift;
  logic [15:0] avg, comp_x, iir_old, iir_new, calc_val, wr_data;
  logic [3:0] iir_addr, calc_addr, wr_addr;
  logic signed [16:0] iir_diff;
  logic [1:0] scl_sync_q, sda_sync_q;
  logic [16:0] req_cnt_q;
  logic serial_q, pulse_active, relay_level, pin_level;
  logic pulse_load_q;
  logic [9:0] word1_q, word2_q;
  logic [15:0] rd_data_q;

  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? 16'(a - b) : 16'h0000;
  endfunction

  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? 16'hffff : s[15:0];
  endfunction

  function automatic logic [15:0] gain_comp(input logic [15:0] x, input logic [15:0] kg);
    logic [31:0] p;
    // widen both factors first so the product keeps its upper half
    p = ({16'h0000, x} * {16'h0000, kg}) >> `KG_FRAC;
    return (|p[31:16]) ? 16'hffff : p[15:0];
  endfunction

  // linear rescale: (t - min) >> shift, clamped to the 10-bit range
  function automatic logic [9:0] rescale(input logic [15:0] t, input logic [15:0] tmin,
                                         input logic [3:0] sh);
    logic [15:0] d;
    d = sat_sub(t, tmin) >> sh;
    return (d > 16'(`PULSE_MAX)) ? `PULSE_MAX : d[9:0];
  endfunction

  function automatic logic [5:0] nvm_word_addr(input logic [2:0] idx);
    unique case (idx)
      3'h0: return `NVM_PULSE_CFG;
      3'h1: return `NVM_HYST;
      3'h2: return `NVM_THR;
      3'h3: return `NVM_RESCALE_MIN;
      default: return `NVM_FILTER_CFG;
    endcase
  endfunction

  // calibration load over the nonvolatile read port
  assign o_nvm_rd = (state_q == SEQ_LOAD) && !nvm_busy_q && (load_idx_q != `NVM_WORDS);
  assign o_nvm_addr = nvm_word_addr(load_idx_q);

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      load_idx_q <= 3'h0;
      nvm_busy_q <= 1'b0;
      pcfg_q <= 16'h0000;
      hyst_q <= 16'h0000;
      thr_q <= 16'h0000;
      rmin_q <= 16'h0000;
      fcfg_q <= 16'h0000;
    end else if (o_nvm_rd) begin
      nvm_busy_q <= 1'b1;
    end else if (nvm_busy_q && i_nvm_ack) begin
      nvm_busy_q <= 1'b0;
      load_idx_q <= 3'(load_idx_q + 3'h1);
      unique case (load_idx_q)
        3'h0: pcfg_q <= i_nvm_rdata;
        3'h1: hyst_q <= i_nvm_rdata;
        3'h2: thr_q <= i_nvm_rdata;
        3'h3: rmin_q <= i_nvm_rdata;
        default: fcfg_q <= i_nvm_rdata;
      endcase
    end
  end

  assign o_dual_zone = fcfg_q[`FCFG_DUAL_BIT];
  assign o_die_sensor_sel = fcfg_q[`FCFG_SENSOR_BIT];

  // filter lengths: fixed for offset and gain, one shared setting otherwise
  assign fixed_len = (step_q == STEP_AMB_OFS) || (step_q == STEP_IR_OFS) ||
                     (step_q == STEP_IR_GAIN);
  assign fir_log2 = fixed_len ? `FIXED_FIR_LOG2 : fcfg_q[`FCFG_FIR_LSB +: 3];
  assign iir_shift = fixed_len ? `FIXED_IIR_SHIFT : fcfg_q[`FCFG_IIR_LSB +: 3];
  assign avg = 16'(acc_q >> fir_log2);
  assign last_sample = (cnt_q == 8'((8'h01 << fir_log2) - 8'h01));

  always_comb begin
    unique case (step_q)
      STEP_AMB_OFS: begin
        comp_x = avg;
        iir_addr = `RAM_TOS;
      end
      STEP_AMB_DIE: begin
        comp_x = sat_sub(avg, ram_q[`RAM_TOS]);
        iir_addr = `RAM_TD;
      end
      STEP_IR_OFS: begin
        comp_x = avg;
        iir_addr = `RAM_IR_OFFSET_RESULT;
      end
      STEP_IR_GAIN: begin
        comp_x = sat_sub(avg, ram_q[`RAM_IR_OFFSET_RESULT]);
        iir_addr = `RAM_IRG;
      end
      STEP_ZONE1: begin
        comp_x = gain_comp(sat_sub(avg, ram_q[`RAM_IR_OFFSET_RESULT]), ram_q[`RAM_KG]);
        iir_addr = `RAM_ZONE1_FILTERED_IR;
      end
      default: begin
        comp_x = gain_comp(sat_sub(avg, ram_q[`RAM_IR_OFFSET_RESULT]), ram_q[`RAM_KG]);
        iir_addr = `RAM_ZONE2_FILTERED_IR;
      end
    endcase
  end

  // first-order low pass; the step never overshoots the new sample
  assign iir_old = ram_q[iir_addr];
  assign iir_diff = $signed({1'b0, comp_x}) - $signed({1'b0, iir_old});
  assign iir_new = 16'($signed({1'b0, iir_old}) + (iir_diff >>> iir_shift));

  always_comb begin
    calc_en = 1'b1;
    calc_addr = `RAM_TA;
    calc_val = 16'h0000;
    unique case (step_q)
      STEP_AMB_DIE: begin
        calc_val = sat_add(`TA_LOW, ram_q[`RAM_TD]);
        if (calc_val > `TA_HIGH) begin
          calc_val = `TA_HIGH;
        end
      end
      STEP_IR_GAIN: begin
        calc_addr = `RAM_KG;
        calc_val = sat_sub(`KG_BASE, ram_q[`RAM_IRG]);
      end
      STEP_ZONE1: begin
        calc_addr = `RAM_ZONE1_OBJECT_TEMP;
        calc_val = sat_add(ram_q[`RAM_TA], ram_q[`RAM_ZONE1_FILTERED_IR]);
      end
      STEP_ZONE2: begin
        calc_addr = `RAM_ZONE2_OBJECT_TEMP;
        calc_val = sat_add(ram_q[`RAM_TA], ram_q[`RAM_ZONE2_FILTERED_IR]);
      end
      default: calc_en = 1'b0;
    endcase
  end

  assign wr_en = (state_q == SEQ_PROC) || ((state_q == SEQ_CALC) && calc_en);
  assign wr_addr = (state_q == SEQ_PROC) ? iir_addr : calc_addr;
  assign wr_data = (state_q == SEQ_PROC) ? iir_new : calc_val;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < 16; i++) begin
        ram_q[i] <= 16'h0000;
      end
    end else if (wr_en) begin
      ram_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_data_q <= 16'h0000;
    end else begin
      rd_data_q <= ram_q[i_ram_rd_addr];
    end
  end
  assign o_ram_rd_data = rd_data_q;

  assign o_adc_start = (state_q == SEQ_START);
  assign o_adc_chan = step_q;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= SEQ_LOAD;
      step_q <= STEP_AMB_OFS;
      cnt_q <= 8'h00;
      acc_q <= 23'h000000;
    end else begin
      unique case (state_q)
        SEQ_LOAD: begin
          if (load_idx_q == `NVM_WORDS) begin
            state_q <= SEQ_START;
          end
        end
        SEQ_START: state_q <= SEQ_WAIT;
        SEQ_WAIT: begin
          if (i_adc_done) begin
            acc_q <= 23'(acc_q + 23'(i_adc_data));
            cnt_q <= 8'(cnt_q + 8'h01);
            state_q <= last_sample ? SEQ_PROC : SEQ_START;
          end
        end
        SEQ_PROC: state_q <= SEQ_CALC;
        SEQ_CALC: begin
          acc_q <= 23'h000000;
          cnt_q <= 8'h00;
          if ((step_q == STEP_ZONE2) || ((step_q == STEP_ZONE1) && !o_dual_zone)) begin
            state_q <= SEQ_PULSE;
          end else begin
            step_q <= step_e'(3'(step_q + 3'h1));
            state_q <= SEQ_START;
          end
        end
        SEQ_PULSE: begin
          step_q <= STEP_AMB_OFS;
          state_q <= SEQ_START;
        end
        default: state_q <= SEQ_LOAD;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pulse_load_q <= 1'b0;
      word1_q <= 10'h000;
      word2_q <= 10'h000;
    end else begin
      pulse_load_q <= (state_q == SEQ_PULSE);
      if (state_q == SEQ_PULSE) begin
        word1_q <= rescale(ram_q[`RAM_ZONE1_OBJECT_TEMP], rmin_q, fcfg_q[`FCFG_SHIFT_LSB +: 4]);
        word2_q <= rescale(o_dual_zone ? ram_q[`RAM_ZONE2_OBJECT_TEMP] : ram_q[`RAM_TA], rmin_q,
                           fcfg_q[`FCFG_SHIFT_LSB +: 4]);
      end
    end
  end
  assign o_pulse_load = pulse_load_q;
  assign o_pulse_word1 = word1_q;
  assign o_pulse_word2 = word2_q;

  relay_hysteresis_comparator u_relay (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_eval((state_q == SEQ_CALC) && (step_q == STEP_ZONE1)),
    .i_object_temp(calc_val),
    .i_threshold(thr_q),
    .i_hysteresis(hyst_q),
    .o_level(relay_level)
  );

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
    end else begin
      scl_sync_q <= {scl_sync_q[0], i_scl_pin};
      sda_sync_q <= {sda_sync_q[0], i_sda_pin};
    end
  end
  assign o_sda_sync = sda_sync_q[1];

  // pulse mode only once the config is in; before that the pin is serial data
  assign pulse_active = (state_q != SEQ_LOAD) && pcfg_q[`PCFG_EN_BIT] && !serial_q;

  // request: clock line low for longer than the request time
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_cnt_q <= 17'h00000;
    end else if (!pulse_active || scl_sync_q[1] || i_sleep_exit) begin
      req_cnt_q <= 17'h00000;
    end else if (req_cnt_q != 17'(REQ_CYCLES)) begin
      req_cnt_q <= 17'(req_cnt_q + 17'h00001);
    end
  end

  // only a reset or a sleep exit returns to pulse or relay operation
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      serial_q <= 1'b0;
    end else if (pulse_active && (req_cnt_q == 17'(REQ_CYCLES))) begin
      serial_q <= 1'b1;
    end else if (i_sleep_exit) begin
      serial_q <= 1'b0;
    end
  end

  assign o_serial_mode = !pulse_active;
  assign o_relay_mode = pulse_active && pcfg_q[`PCFG_RELAY_BIT];
  assign pin_level = o_relay_mode ? relay_level : i_pulse_level;

  always_comb begin
    if (!pulse_active) begin
      o_sda_out = 1'b0;
      o_sda_oe_n = !i_serial_drive_low;
    end else if (pcfg_q[`PCFG_DRIVE_BIT]) begin
      o_sda_out = pin_level;
      o_sda_oe_n = 1'b0;
    end else begin
      o_sda_out = 1'b0;
      o_sda_oe_n = pin_level;
    end
  end
endmodule
`default_nettype wire

// ---- core/relay_hysteresis_comparator.sv ----
// hysteresis comparator producing the relay logic level
`default_nettype none
module relay_hysteresis_comparator (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_eval,
  input wire logic [15:0] i_object_temp,
  input wire logic [15:0] i_threshold,
  input wire logic [15:0] i_hysteresis,
  output logic o_level
);
  // temperature is 0.02 K per lsb, limits 0.01 K per lsb: double the temperature
  logic signed [17:0] temp_x2;
  logic signed [17:0] upper;
  logic signed [17:0] lower;

  assign temp_x2 = $signed({1'b0, i_object_temp, 1'b0});
  assign upper = $signed({2'b00, i_threshold}) + $signed({2'b00, i_hysteresis});
  assign lower = $signed({2'b00, i_threshold}) - $signed({2'b00, i_hysteresis});

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_level <= 1'b0;
    end else if (i_eval) begin
      if (temp_x2 >= upper) begin
        o_level <= 1'b1;
      end else if (temp_x2 <= lower) begin
        o_level <= 1'b0;
      end
      // between the points the level holds
    end
  end
endmodule
`default_nettype wire

// ---- verification/ir_relay_assertions.sv ----
// concurrent checks on the thermometer sequencer ports
`default_nettype none
module ir_relay_assertions #(
  parameter int REQ_CYCLES = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic o_nvm_rd,
  input wire logic [5:0] o_nvm_addr,
  input wire logic o_adc_start,
  input wire logic o_pulse_load,
  input wire logic i_scl_pin,
  input wire logic i_serial_drive_low,
  input wire logic i_sleep_exit,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic o_serial_mode,
  input wire logic o_relay_mode
);
  int low_cnt_q;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);
  // counts raw clock-pin low time; saturates so a held pin cannot wrap
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_q <= 0;
    end else if (i_scl_pin) begin
      low_cnt_q <= 0;
    end else if (low_cnt_q < REQ_CYCLES + 8) begin
      low_cnt_q <= low_cnt_q + 1;
    end
  end
  sequence s_req_held;
    low_cnt_q == REQ_CYCLES + 6;
  endsequence
  sequence s_quiet_sleep;
    i_scl_pin [*3] ##0 i_sleep_exit;
  endsequence
  chk_boot_first_read: assert property ($rose(i_reset_n) |->
    o_nvm_rd && o_nvm_addr == 6'h02)
    else $error("first calibration read missing");
  chk_nvm_one_cycle: assert property (o_nvm_rd |=> !o_nvm_rd)
    else $error("calibration read longer than one cycle");
  chk_adc_one_cycle: assert property (o_adc_start |=> !o_adc_start)
    else $error("conversion start longer than one cycle");
  chk_load_restarts: assert property (o_pulse_load |-> o_adc_start ##1 !o_pulse_load)
    else $error("pulse load not followed by loop restart");
  chk_serial_pin_drive: assert property (o_serial_mode |->
    o_sda_oe_n == !i_serial_drive_low && !o_sda_out)
    else $error("serial pin drive wrong");
  chk_relay_not_serial: assert property (o_relay_mode |-> !o_serial_mode)
    else $error("relay and serial modes together");
  chk_request_taken: assert property (s_req_held |-> o_serial_mode)
    else $error("long clock low did not select serial");
  chk_serial_cause: assert property ($rose(o_serial_mode) |-> low_cnt_q >= REQ_CYCLES)
    else $error("serial mode entered without request");
  chk_sleep_clears: assert property (s_quiet_sleep |=> !o_serial_mode)
    else $error("sleep exit did not leave serial mode");
endmodule
`default_nettype wire

// ---- verification/nvm_adc_model.sv ----
// far-side model: calibration word store and converter
`default_nettype none
module nvm_adc_model (
  input wire logic i_clk,
  input wire logic i_rd,
  input wire logic [5:0] i_addr,
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic [15:0] i_sample,
  input wire logic [15:0] i_cfg,
  input wire logic [15:0] i_hyst,
  input wire logic [15:0] i_thr,
  input wire logic [15:0] i_filt,
  output logic o_ack,
  output logic [15:0] o_rdata,
  output logic o_done,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] a;
  initial begin
    o_ack = 1'b0;
    o_done = 1'b0;
    o_rdata = 16'h0;
    o_data = 16'h0;
  end
  // data is inverted once ack drops so a stale word is never mistaken for valid
  always @(posedge i_clk) begin
    if (i_rd) begin
      a = i_addr;
      repeat (i_slow ? 4 : 0) @(posedge i_clk);
      o_ack <= 1'b1;
      o_rdata <= a == 6'h02 ? i_cfg : a == 6'h20 ? i_hyst : a == 6'h21 ? i_thr :
                 a == 6'h22 ? 16'h2de4 : a == 6'h25 ? i_filt : 16'hffff;
      @(posedge i_clk);
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
    end
  end
  always @(posedge i_clk) begin
    if (i_start) begin
      repeat (i_slow ? 3 : 0) @(posedge i_clk);
      o_done <= 1'b1;
      o_data <= i_sample;
      @(posedge i_clk);
      o_done <= 1'b0;
      o_data <= ~i_sample;
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the thermometer sequencer and relay pin
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REQ = 20;
  logic i_ref_clk, i_reset_n, o_nvm_rd, i_nvm_ack, o_adc_start, i_adc_done, o_pulse_load;
  logic i_pulse_level, i_scl_pin, i_sda_pin, o_sda_sync, i_serial_drive_low, i_sleep_exit;
  logic o_sda_out, o_sda_oe_n, o_serial_mode, o_relay_mode, o_dual_zone, o_die_sensor_sel;
  logic rnd;
  logic slow = 1'b0;
  logic [5:0] o_nvm_addr;
  logic [15:0] i_nvm_rdata, i_adc_data, o_ram_rd_data, w_cfg, w_thr, w_hyst, w_filt, d;
  logic [15:0] sample = 16'h0;
  logic [3:0] i_ram_rd_addr;
  logic [2:0] o_adc_chan;
  logic [9:0] o_pulse_word1, o_pulse_word2;
  logic [31:0] lfsr = 32'hce23;
  logic [2:0] chan_q[$];
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  int live = 0;
  logic sda_q;
  ir_thermometer_relay_output #(.REQ_CYCLES(REQ)) ir_thermometer_relay_output_i (
    .i_ref_clk, .i_reset_n, .o_nvm_rd, .o_nvm_addr, .i_nvm_ack, .i_nvm_rdata, .o_adc_start,
    .o_adc_chan, .i_adc_done, .i_adc_data, .i_ram_rd_addr, .o_ram_rd_data, .o_pulse_load,
    .o_pulse_word1, .o_pulse_word2, .i_pulse_level, .i_scl_pin, .i_sda_pin, .o_sda_sync,
    .i_serial_drive_low, .i_sleep_exit, .o_sda_out, .o_sda_oe_n, .o_serial_mode,
    .o_relay_mode, .o_dual_zone, .o_die_sensor_sel);
  nvm_adc_model nvm_adc_model_i (.i_clk(i_ref_clk), .i_rd(o_nvm_rd), .i_addr(o_nvm_addr),
    .i_start(o_adc_start), .i_slow(slow), .i_sample(sample), .i_cfg(w_cfg), .i_hyst(w_hyst),
    .i_thr(w_thr), .i_filt(w_filt), .o_ack(i_nvm_ack), .o_rdata(i_nvm_rdata),
    .o_done(i_adc_done), .o_data(i_adc_data));
  function automatic logic [31:0] next_lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] act, input logic [15:0] exp);
    n_checks++;
    if (act !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    i_ram_rd_addr = a;
    @(negedge i_ref_clk);
    v = o_ram_rd_data;
  endtask
  task automatic run(input logic [15:0] cfg, thr, hyst, filt);
    int n;
    int s;
    i_reset_n = 1'b0;
    w_cfg = cfg;
    w_thr = thr;
    w_hyst = hyst;
    w_filt = filt;
    repeat (10) @(negedge i_ref_clk);
    chan_q.delete();
    for (s = 0; s < 6; s++) begin
      n = (s == 1 || s >= 4) ? (1 << filt[2:0]) : 8;
      if (s < 5 || filt[8]) repeat (n) chan_q.push_back(3'(s));
    end
    i_reset_n = 1'b1;
    n = 0;
    while (o_pulse_load !== 1'b1 && n < 4000) begin
      @(negedge i_ref_clk);
      n++;
    end
    check(16'(o_pulse_load), 16'h1);
    if (!rnd) check(16'(o_pulse_word1), 16'h0);
    if (!rnd) check(16'(o_pulse_word2), 16'h0);
    check(16'(chan_q.size()), 16'h0);
    check(16'({o_dual_zone, o_die_sensor_sel}), 16'({filt[8], filt[9]}));
    @(negedge i_ref_clk);
  endtask
  // the converter channel requests are compared in order against the expected step plan
  always @(negedge i_ref_clk) begin
    if (o_adc_start === 1'b1 && chan_q.size() > 0) begin
      check(16'(o_adc_chan), 16'(chan_q.pop_front()));
    end
  end
  always @(negedge i_ref_clk) begin
    lfsr <= next_lfsr(lfsr);
    slow <= lfsr[3];
    sample <= rnd ? lfsr[15:0] : 16'h0;
    i_sda_pin <= o_sda_oe_n ? lfsr[5] : o_sda_out;
    // the synchronised data pin trails the pin by two edges
    sda_q <= i_sda_pin;
    live <= i_reset_n ? live + 1 : 0;
    if (i_reset_n && live > 2) check(16'(o_sda_sync), 16'(sda_q));
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    logic [15:0] cfg[5] = '{16'h0000, 16'h000e, 16'h000a, 16'h0002, 16'h000a};
    logic [15:0] thr[5] = '{16'h0, 16'h5bc7, 16'h5bc9, 16'h0, 16'h0};
    logic [15:0] hys[5] = '{16'h0, 16'h1, 16'h1, 16'h0, 16'h0};
    logic [15:0] flt[5] = '{16'h0001, 16'h0102, 16'h0200, 16'h0000, 16'h0100};
    logic [1:0] pin[5] = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b01};
    i_reset_n = 1'b0;
    i_ram_rd_addr = 4'h0;
    i_pulse_level = 1'b0;
    i_scl_pin = 1'b1;
    i_serial_drive_low = 1'b0;
    i_sleep_exit = 1'b0;
    rnd = 1'b0;
    for (int k = 0; k < 5; k++) begin
      rnd = (k == 4);
      run(cfg[k], thr[k], hys[k], flt[k]);
      check(16'({o_sda_out, o_sda_oe_n}), 16'(pin[k]));
      check(16'({o_serial_mode, o_relay_mode}), 16'({~cfg[k][1], cfg[k][3] & cfg[k][1]}));
      rd(4'h6, d);
      if (k < 4) check(d, 16'h2de4);
      else check(16'(d >= 16'h2de4 && d <= 16'h4dc4), 16'h1);
      rd(4'h7, d);
      if (k < 4) check(d, 16'h2de4);
      else check(16'(o_pulse_word1), (d > 16'h31e3) ? 16'h3ff : 16'(d - 16'h2de4));
      if (k == 0) begin
        i_serial_drive_low = 1'b1;
        @(negedge i_ref_clk);
        check(16'({o_sda_out, o_sda_oe_n}), 16'h0);
        i_serial_drive_low = 1'b0;
      end
      if (k == 3) begin
        i_pulse_level = 1'b1;
        @(negedge i_ref_clk);
        check(16'({o_sda_out, o_sda_oe_n}), 16'h1);
        i_pulse_level = 1'b0;
      end
    end
    // request only sent while pulse output is enabled
    i_scl_pin = 1'b0;
    repeat (REQ + 8) @(negedge i_ref_clk);
    check(16'({o_serial_mode, o_relay_mode}), 16'h2);
    i_scl_pin = 1'b1;
    d = 16'h0;
    repeat (200) begin
      @(negedge i_ref_clk);
      if (o_adc_start === 1'b1) d = 16'h1;
    end
    check(d, 16'h1);
    repeat (4) @(negedge i_ref_clk);
    i_sleep_exit = 1'b1;
    @(negedge i_ref_clk);
    i_sleep_exit = 1'b0;
    @(negedge i_ref_clk);
    check(16'({o_serial_mode, o_relay_mode}), 16'h1);
    report_and_stop();
  end
endmodule
bind ir_thermometer_relay_output ir_relay_assertions #(.REQ_CYCLES(REQ_CYCLES))
  ir_relay_assertions_i (.i_ref_clk, .i_reset_n, .o_nvm_rd, .o_nvm_addr, .o_adc_start,
  .o_pulse_load, .i_scl_pin, .i_serial_drive_low, .i_sleep_exit, .o_sda_out, .o_sda_oe_n,
  .o_serial_mode, .o_relay_mode);
`default_nettype wire
